// File: design/cfgw_pkg.sv
// Constants shared by the configuration word decoder and its watchdog.
// Assumes a 20 MHz device clock and a 14-bit one-time-programmable word.
package cfgw_pkg;

    // Word geometry and location
    localparam int          CFG_W          = 14;
    localparam logic [13:0] CFG_ADDR       = 14'h2007;
    localparam logic [13:0] CFG_ERASED     = 14'h3fff;

    // Field positions
    localparam int CP_COPY0_LSB = 4;
    localparam int CP_COPY1_LSB = 8;
    localparam int CP_COPY2_LSB = 10;
    localparam int CP_COPY3_LSB = 12;
    localparam int CP_COPIES    = 4;
    localparam int UNIMPL_BIT   = 7;
    localparam int BOREN_BIT    = 6;
    localparam int PWRTEN_BIT   = 3;
    localparam int WDTEN_BIT    = 2;
    localparam int OSC_LSB      = 0;

    // Code protection encodings
    localparam logic [1:0] CP_OFF        = 2'h3;
    localparam logic [1:0] CP_UPPER_HALF = 2'h2;
    localparam logic [1:0] CP_UPPER_3Q   = 2'h1;
    localparam logic [1:0] CP_ALL        = 2'h0;

    // Protected quarters of program memory
    localparam logic [2:0] PQ_NONE = 3'h0;
    localparam logic [2:0] PQ_HALF = 3'h2;
    localparam logic [2:0] PQ_3Q   = 3'h3;
    localparam logic [2:0] PQ_ALL  = 3'h4;

    // Oscillator modes
    localparam logic [1:0] OSC_RC = 2'h3;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_XT = 2'h1;
    localparam logic [1:0] OSC_LP = 2'h0;

    // Power-up delay timer
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          POWERUP_DELAY_TIMER_MS     = 72;
    localparam int          POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
    localparam int          POWERUP_DELAY_TIMER_CNT_W  = 21;

    // Watchdog: ticks of its own oscillator before a timeout
    localparam int          WDT_CNT_W   = 8;
    localparam logic [7:0]  WDT_TICKS   = 8'hff;

    // Start-up and run states
    typedef enum logic [2:0] {
        ST_CAPTURE, ST_POWERUP_DELAY_TIMER, ST_OST, ST_RUN, ST_SLEEP, ST_PROG
    } cfgw_state_type;

endpackage

// File: design/cfgw_wdog.sv
// Watchdog counter clocked by ticks of its own RC oscillator.
// Assumes the tick pin is asynchronous to CLK and slower than CLK / 4.
`timescale 1ns/10ps
module cfgw_wdog
    import cfgw_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic tick_pin,
    input  wire logic clear,
    output logic      timeout
);

    logic                 sync1_r;   // First synchroniser stage
    logic                 sync2_r;   // Second synchroniser stage
    logic                 sync3_r;   // Edge history
    logic [WDT_CNT_W-1:0] cnt_r;     // Ticks since last clear
    logic                 tick;      // One tick of the RC oscillator

    // Bring the oscillator into the clock domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // All high, so a pin already high gives no false tick
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
        end else begin
            sync1_r <= tick_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign tick = sync2_r & ~sync3_r;

    // Count ticks; only the configuration enable stops it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r   <= '0;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (!enable || clear) begin
                cnt_r <= '0;
            end else if (tick) begin
                if (cnt_r == WDT_TICKS) begin
                    cnt_r   <= '0;
                    timeout <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    // Timeout never fires while disabled
    property p_wdt_off;
        @(posedge clk) disable iff (rst)
        !enable |=> !timeout;
    endproperty
    a_wdt_off: assert property (p_wdt_off)
        else $error("watchdog fired while disabled");

endmodule

// File: design/cfgw_decode.sv
// Configuration word store, decoder and start-up sequencer.
// Assumes the programming port is driven by on-chip programming logic
// on CLK; the oscillator-stable, reset and watchdog-tick pins are async.
`timescale 1ns/10ps

// Overview of operation
// - Programmed bit reads 0, unprogrammed reads 1
// - Word at 2007h, programming mode only
// - Code protect field decodes four protection levels
// - Bit seven always reads back as 1
// - Bit six enables brown-out reset
// - Bit three low enables power-up timer
// - Brown-out enable forces power-up timer on
// - Bit two enables the watchdog
// - Watchdog on own oscillator, config-only disable
// - Two bits select RC, HS, XT, LP
// - Power-up timer holds reset 72 ms once
// - Start-up timer holds reset until stable in crystal modes
// - Sleep ends on reset, watchdog or interrupt
// - Crystal modes also accept external clock
module cfgw_decode
    import cfgw_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_CNT = POWERUP_DELAY_TIMER_CYCLES
)
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PROG_MODE,
    input  wire logic [13:0] PROG_ADDR,
    input  wire logic [13:0] PROG_WDATA,
    input  wire logic        PROG_WE,
    input  wire logic        PROG_RE,
    output logic      [13:0] PROG_RDATA,
    input  wire logic        OSC_STABLE,
    input  wire logic        WDT_OSC_TICK,
    input  wire logic        WDT_CLEAR,
    input  wire logic        SLEEP_REQ,
    input  wire logic        IRQ_PENDING,
    input  wire logic        EXT_RESET_N,
    output logic [2:0]       PROTECTED_QUARTERS,
    output logic             CP_CONSISTENT,
    output logic             BROWNOUT_RESET_ENABLE,
    output logic             POWERUP_TIMER_ACTIVE,
    output logic             WATCHDOG_ENABLE,
    output logic [1:0]       OSC_MODE_SELECT,
    output logic             EXT_CLOCK_ALLOWED,
    output logic             CORE_RESET_HOLD,
    output logic             SLEEPING,
    output logic             WDT_RESET
);

    // Map a code protect pair to protected quarters
    function automatic logic [2:0] cp_decode(input logic [1:0] f);
        case (f)
            CP_OFF:        cp_decode = PQ_NONE;
            CP_UPPER_HALF: cp_decode = PQ_HALF;
            CP_UPPER_3Q:   cp_decode = PQ_3Q;
            default:       cp_decode = PQ_ALL;
        endcase
    endfunction

    // True for the three crystal oscillator modes
    function automatic logic is_crystal(input logic [1:0] m);
        is_crystal = (m != OSC_RC);
    endfunction

    logic [CFG_W-1:0]      word_r = CFG_ERASED; // Blank at power-up
    logic [CFG_W-1:0]      word_rd;     // Word as seen on read
    logic [1:0]            cp_copy [CP_COPIES];
    logic [CP_COPIES-1:0]  cp_same;     // Copy matches copy 0
    cfgw_state_type        state_r;     // Start-up sequencer state
    cfgw_state_type        state_nxt;
    logic [POWERUP_DELAY_TIMER_CNT_W-1:0] powerup_delay_timer_r;      // Power-up delay count
    logic                  stable_s1_r; // Oscillator stable sync
    logic                  stable_s2_r;
    logic                  xrst_s1_r;   // External reset sync
    logic                  xrst_s2_r;
    logic                  prog_s1_r;   // Programming mode sync
    logic                  prog_s2_r;
    logic                  wdt_to;      // Watchdog timeout pulse
    logic                  wake;        // Any wake-up source

    // Unimplemented bit forced high on every read
    always_comb begin
        word_rd             = word_r;
        word_rd[UNIMPL_BIT] = 1'b1;
    end

    // Gather the four code protect copies
    assign cp_copy[0] = word_rd[CP_COPY0_LSB +: 2];
    assign cp_copy[1] = word_rd[CP_COPY1_LSB +: 2];
    assign cp_copy[2] = word_rd[CP_COPY2_LSB +: 2];
    assign cp_copy[3] = word_rd[CP_COPY3_LSB +: 2];

    // Compare every copy against the first
    genvar gi;
    generate
        for (gi = 0; gi < CP_COPIES; gi++) begin : g_cp
            assign cp_same[gi] = (cp_copy[gi] == cp_copy[0]);
        end
    endgenerate

    // Synchronise pins from outside the clock domain
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stable_s1_r <= 1'b0;
            stable_s2_r <= 1'b0;
            xrst_s1_r   <= 1'b1;
            xrst_s2_r   <= 1'b1;
            prog_s1_r   <= 1'b0;
            prog_s2_r   <= 1'b0;
        end else begin
            stable_s1_r <= OSC_STABLE;
            stable_s2_r <= stable_s1_r;
            xrst_s1_r   <= EXT_RESET_N;
            xrst_s2_r   <= xrst_s1_r;
            prog_s1_r   <= PROG_MODE;
            prog_s2_r   <= prog_s1_r;
        end
    end

    // One-time store: programming only turns bits from 1 to 0
    // Written only in programming mode at its own address
    // Not cleared by RST: a burned word must survive every restart
    // so that the next start-up decodes it
    always_ff @(posedge CLK) begin
        if (prog_s2_r && PROG_WE && PROG_ADDR == CFG_ADDR) begin
            word_r <= word_r & PROG_WDATA;
        end
    end

    // Read-back exists only in programming mode
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PROG_RDATA <= CFG_ERASED;
        end else if (prog_s2_r && PROG_RE && PROG_ADDR == CFG_ADDR) begin
            PROG_RDATA <= word_rd;
        end else begin
            PROG_RDATA <= CFG_ERASED;
        end
    end

    // Latch decoded fields once, right after reset release
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PROTECTED_QUARTERS    <= PQ_ALL;
            CP_CONSISTENT         <= 1'b0;
            BROWNOUT_RESET_ENABLE <= 1'b0;
            POWERUP_TIMER_ACTIVE  <= 1'b1;
            WATCHDOG_ENABLE       <= 1'b0;
            OSC_MODE_SELECT       <= OSC_LP;
            EXT_CLOCK_ALLOWED     <= 1'b0;
        end else if (state_r == ST_CAPTURE) begin
            // Mixed copies fall back to full protection
            PROTECTED_QUARTERS    <= (&cp_same) ? cp_decode(cp_copy[0])
                                                : PQ_ALL;
            CP_CONSISTENT         <= &cp_same;
            // Brown-out enable is active high
            BROWNOUT_RESET_ENABLE <= word_rd[BOREN_BIT];
            // Timer enable is active low, forced by brown-out
            POWERUP_TIMER_ACTIVE  <= ~word_rd[PWRTEN_BIT]
                                     | word_rd[BOREN_BIT];
            // Watchdog enable is active high
            WATCHDOG_ENABLE       <= word_rd[WDTEN_BIT];
            // Oscillator mode taken straight from the word
            OSC_MODE_SELECT       <= word_rd[OSC_LSB +: 2];
            // Crystal modes may take a driven clock instead
            EXT_CLOCK_ALLOWED     <= is_crystal(word_rd[OSC_LSB +: 2]);
        end
    end

    // Watchdog on its own oscillator; no software disable
    cfgw_wdog u_wdog (
        .clk      (CLK),
        .rst      (RST),
        .enable   (WATCHDOG_ENABLE),
        .tick_pin (WDT_OSC_TICK),
        .clear    (WDT_CLEAR),
        .timeout  (wdt_to)
    );

    // Wake on external reset, watchdog or enabled interrupt
    assign wake = ~xrst_s2_r | wdt_to | IRQ_PENDING;

    // Next-state logic of the start-up sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_CAPTURE: begin
                // Power-up delay only on this first pass
                if (powerup_delay_timer_needed(word_rd)) begin
                    state_nxt = ST_POWERUP_DELAY_TIMER;
                end else begin
                    state_nxt = ST_OST;
                end
            end
            ST_POWERUP_DELAY_TIMER: begin
                if (powerup_delay_timer_r == POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_TIMER_CNT - 1)) begin
                    state_nxt = ST_OST;
                end
            end
            ST_OST: begin
                // Crystal modes wait for a stable oscillator
                if (!is_crystal(OSC_MODE_SELECT) || stable_s2_r) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (prog_s2_r) begin
                    state_nxt = ST_PROG;
                end else if (SLEEP_REQ) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    state_nxt = ST_OST;
                end
            end
            ST_PROG: begin
                if (!prog_s2_r) begin
                    state_nxt = ST_OST;
                end
            end
            default: state_nxt = ST_CAPTURE;
        endcase
    end

    // Timer need from the word itself, valid in the capture cycle
    function automatic logic powerup_delay_timer_needed(input logic [CFG_W-1:0] w);
        powerup_delay_timer_needed = ~w[PWRTEN_BIT]
                      | w[BOREN_BIT];
    endfunction

    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= ST_CAPTURE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Power-up delay counter, runs only in its state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            powerup_delay_timer_r <= '0;
        end else if (state_r == ST_POWERUP_DELAY_TIMER) begin
            powerup_delay_timer_r <= powerup_delay_timer_r + 1'b1;
        end else begin
            powerup_delay_timer_r <= '0;
        end
    end

    // Core held in reset until running
    assign CORE_RESET_HOLD = (state_r != ST_RUN);
    assign SLEEPING        = (state_r == ST_SLEEP);

    // Watchdog timeout while running resets the core
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WDT_RESET <= 1'b0;
        end else begin
            WDT_RESET <= wdt_to && state_r == ST_RUN;
        end
    end

    // Read-back forces the unimplemented bit
    property p_bit7;
        @(posedge CLK) disable iff (RST)
        (prog_s2_r && PROG_RE && PROG_ADDR == CFG_ADDR)
            |=> PROG_RDATA[UNIMPL_BIT];
    endproperty
    a_bit7: assert property (p_bit7)
        else $error("unimplemented bit read as zero");

    // Outside programming mode the word is not visible
    property p_noread;
        @(posedge CLK) disable iff (RST)
        !prog_s2_r |=> PROG_RDATA == CFG_ERASED;
    endproperty
    a_noread: assert property (p_noread)
        else $error("word read outside programming mode");

    // Programmed bits never return to one
    property p_otp;
        @(posedge CLK) disable iff (RST)
        1'b1 |=> (word_r & ~$past(word_r)) == '0;
    endproperty
    a_otp: assert property (p_otp)
        else $error("programmed bit was erased");

    // Brown-out enable forces the power-up timer
    property p_bor_powerup_delay_timer;
        @(posedge CLK) disable iff (RST)
        BROWNOUT_RESET_ENABLE |-> POWERUP_TIMER_ACTIVE;
    endproperty
    a_bor_powerup_delay_timer: assert property (p_bor_powerup_delay_timer)
        else $error("power-up timer off with brown-out on");

    // Decoded fields never change after capture
    property p_hold;
        @(posedge CLK) disable iff (RST)
        state_r != ST_CAPTURE |=> $stable(OSC_MODE_SELECT)
            && $stable(WATCHDOG_ENABLE) && $stable(PROTECTED_QUARTERS);
    endproperty
    a_hold: assert property (p_hold)
        else $error("decoded field changed after capture");

    // Mixed protection copies give full protection
    property p_cp_mix;
        @(posedge CLK) disable iff (RST)
        !CP_CONSISTENT && state_r != ST_CAPTURE
            |-> PROTECTED_QUARTERS == PQ_ALL;
    endproperty
    a_cp_mix: assert property (p_cp_mix)
        else $error("mixed protection copies not fully protected");

    // Power-up delay lasts at least eight cycles before start-up
    property p_powerup_delay_timer_len;
        @(posedge CLK) disable iff (RST)
        $rose(state_r == ST_POWERUP_DELAY_TIMER) |-> (state_r == ST_POWERUP_DELAY_TIMER)[*8];
    endproperty
    a_powerup_delay_timer_len: assert property (p_powerup_delay_timer_len)
        else $error("power-up delay ended early");

    // No run before a crystal oscillator is stable
    property p_ost;
        @(posedge CLK) disable iff (RST)
        state_r == ST_OST && is_crystal(OSC_MODE_SELECT) && !stable_s2_r
            |=> CORE_RESET_HOLD;
    endproperty
    a_ost: assert property (p_ost)
        else $error("core released before oscillator stable");

    // Sleep ends one cycle after a wake source
    property p_wake;
        @(posedge CLK) disable iff (RST)
        SLEEPING && wake |=> !SLEEPING;
    endproperty
    a_wake: assert property (p_wake)
        else $error("sleep not left on wake-up");

    // Crystal modes accept a driven clock
    property p_extclk;
        @(posedge CLK) disable iff (RST)
        state_r != ST_CAPTURE
            |-> EXT_CLOCK_ALLOWED == (OSC_MODE_SELECT != OSC_RC);
    endproperty
    a_extclk: assert property (p_extclk)
        else $error("external clock permission wrong");

endmodule

// File: tb/cfgw_programmer.sv
// Programmer model driving the configuration word programming port.
// Assumes the device clock on clk; requests change after rising edges.
`timescale 1ns/10ps
module cfgw_programmer (
    input  wire logic        clk,
    output logic             mode,
    output logic [13:0]      addr,
    output logic [13:0]      wdata,
    output logic             we,
    output logic             re,
    input  wire logic [13:0] rdata
);
    // Idle port at time zero
    initial begin
        mode = 1'b0;
        addr = 14'h0000;
        wdata = 14'h0000;
        we = 1'b0;
        re = 1'b0;
    end

    // Mode level held well past the synchroniser delay
    task automatic set_mode(input logic on);
        @(posedge clk) mode <= on;
        repeat (4) @(posedge clk);
    endtask

    // One strobed cycle; read data stands the cycle after the strobe
    task automatic access(input logic wr, input logic [13:0] a,
                          input logic [13:0] d, output logic [13:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= wr;
        re <= !wr;
        @(posedge clk);
        we <= 1'b0;
        re <= 1'b0;
        addr <= ~a;         // Released lines scrambled, not held
        wdata <= ~d;
        #1 q = rdata;
    endtask
endmodule

// File: tb/cfgw_decode_bench.sv
// Self-checking bench for the configuration word decoder.
// Assumes two decoder copies, each beside its own programmer model.
`timescale 1ns/10ps
module cfgw_decode_bench
    import cfgw_pkg::*;
;
    localparam int PCNT = 16;         // Short power-up delay
    logic        clk, rst, osc_stable, irq, ext_rst_n, sleep_req;
    logic        clr_en, wdt_clear;   // Watchdog servicing
    logic [2:0]  tdiv;                // Watchdog tick divider
    logic        pm[2], pw[2], pr[2], cpc[2], bor[2], pwa[2], wde[2];
    logic        ext[2], hold[2], slp[2], wdr[2];
    logic [13:0] pa[2], pd[2], rd[2];
    logic [2:0]  pq3[2];
    logic [1:0]  osc[2];
    logic [13:0] q;                   // Read-back word
    int          fails, tests_run, wdr_cnt, cycles, n, w0;

    // Decoder copies, each with a programmer
    for (genvar g = 0; g < 2; g++) begin : gi
        cfgw_programmer prog (.clk(clk), .mode(pm[g]), .addr(pa[g]),
            .wdata(pd[g]), .we(pw[g]), .re(pr[g]), .rdata(rd[g]));
        cfgw_decode #(.POWERUP_DELAY_TIMER_CNT(PCNT)) uut (.CLK(clk), .RST(rst),
            .PROG_MODE(pm[g]), .PROG_ADDR(pa[g]), .PROG_WDATA(pd[g]),
            .PROG_WE(pw[g]), .PROG_RE(pr[g]), .PROG_RDATA(rd[g]),
            .OSC_STABLE(osc_stable), .WDT_OSC_TICK(tdiv[2]),
            .WDT_CLEAR(wdt_clear), .SLEEP_REQ(sleep_req),
            .IRQ_PENDING(irq), .EXT_RESET_N(ext_rst_n),
            .PROTECTED_QUARTERS(pq3[g]), .CP_CONSISTENT(cpc[g]),
            .BROWNOUT_RESET_ENABLE(bor[g]), .POWERUP_TIMER_ACTIVE(pwa[g]),
            .WATCHDOG_ENABLE(wde[g]), .OSC_MODE_SELECT(osc[g]),
            .EXT_CLOCK_ALLOWED(ext[g]), .CORE_RESET_HOLD(hold[g]),
            .SLEEPING(slp[g]), .WDT_RESET(wdr[g]));
    end

    // Clock
    always #25 clk = ~clk;

    // Watchdog ticks at CLK/8, optional servicing, pulse counting
    always @(posedge clk) begin
        tdiv <= tdiv + 3'h1;
        wdt_clear <= clr_en && (tdiv == 3'h0);
        if (wdr[0] === 1'b1) wdr_cnt <= wdr_cnt + 1;
        cycles <= cycles + 1;
    end

    // Hang guard
    always @(posedge clk) begin
        if (cycles == 16000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    // Expected decode from a stored word
    function automatic logic [9:0] exp_dec(input logic [13:0] w);
        logic [2:0] p;
        logic       same;
        same = (w[13:12] == w[5:4]) && (w[11:10] == w[5:4])
            && (w[9:8] == w[5:4]);
        case (w[5:4])
            2'h3: p = 3'h0;
            2'h2: p = 3'h2;
            2'h1: p = 3'h3;
            default: p = 3'h4;
        endcase
        if (!same) p = 3'h4;  // Mixed copies fall back to full
        return {p, same, w[6], !w[3] || w[6], w[2], w[1:0], w[1:0] != 2'h3};
    endfunction

    // Decoded outputs of one copy
    function automatic logic [9:0] dec(input int i);
        return {pq3[i], cpc[i], bor[i], pwa[i], wde[i], osc[i], ext[i]};
    endfunction

    // Compare and count
    task automatic check(input string what, input logic [13:0] e,
                         input logic [13:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask

    // Reset, then time the hold and compare both decodes
    task automatic boot(input logic [13:0] wa, input logic [13:0] wb,
                        input int lo, input int hi, input logic run);
        @(posedge clk) rst <= 1'b1;
        repeat (5) @(posedge clk);
        #1 check("reset outputs", 14'h0a10,
                 {2'h0, hold[0], slp[0], dec(0)});
        check("reset rdata", 14'h3fff, rd[0]);
        @(posedge clk) rst <= 1'b0;
        @(posedge clk);
        #1 n = 0;
        while (hold[0] === 1'b1 && n < hi) begin
            @(posedge clk);
            #1 n++;
        end
        check("hold", {12'h0, !run, 1'b1},
              {12'h0, hold[0], n >= lo});
        check("decode a", {4'h0, exp_dec(wa)}, {4'h0, dec(0)});
        check("decode b", {4'h0, exp_dec(wb)}, {4'h0, dec(1)});
    endtask

    // Program copy A while running
    task automatic burn(input logic [13:0] w);
        gi[0].prog.set_mode(1'b1);
        gi[0].prog.access(1'b1, CFG_ADDR, w, q);
        gi[0].prog.set_mode(1'b0);
    endtask

    // Wait on the watchdog pulse count
    task automatic wdt_wait(input int lim);
        n = 0;
        while (wdr_cnt == w0 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    // Closing report
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        osc_stable = 1'b1;
        irq = 1'b0;
        ext_rst_n = 1'b1;
        sleep_req = 1'b0;
        clr_en = 1'b0;
        wdt_clear = 1'b0;
        tdiv = 3'h0;
        {fails, tests_run, wdr_cnt, cycles} = '0;
        boot(CFG_ERASED, CFG_ERASED, PCNT, PCNT + 8, 1'b1);
        // Interrupt, external reset and watchdog wakes
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) sleep_req <= 1'b1;
            @(posedge clk) sleep_req <= 1'b0;
            @(posedge clk) begin
                irq <= (k == 0);
                ext_rst_n <= (k != 1);
            end
            #1 check("asleep", 14'h3, {12'h0, slp[0], slp[1]});
            w0 = wdr_cnt;
            n = 0;
            while (slp[0] === 1'b1 && n < 2400) begin
                @(posedge clk);
                #1 n++;
            end
            check("no pulse asleep", 14'(w0), 14'(wdr_cnt));
            @(posedge clk) begin
                irq <= 1'b0;
                ext_rst_n <= 1'b1;
            end
            repeat (8) @(posedge clk);
            #1 check("woken", 14'h0,
                     {10'h0, slp[0], hold[0], slp[1], hold[1]});
        end
        // Serviced watchdog stays quiet, then fires once
        @(posedge clk) clr_en <= 1'b1;
        w0 = wdr_cnt;
        wdt_wait(2400);
        check("serviced", 14'(w0), 14'(wdr_cnt));
        @(posedge clk) clr_en <= 1'b0;
        wdt_wait(2400);
        check("timeout", 14'(w0 + 1), 14'(wdr_cnt));
        // Programming port
        gi[0].prog.access(1'b1, CFG_ADDR, 14'h0000, q);
        gi[0].prog.set_mode(1'b1);
        #1 check("hold in prog", 14'h1, {13'h0, hold[0]});
        gi[0].prog.access(1'b1, 14'h2006, 14'h0000, q);
        gi[0].prog.access(1'b0, CFG_ADDR, 14'h0000, q);
        check("word", 14'h3fff, q);
        gi[0].prog.access(1'b1, CFG_ADDR, 14'h2a2e, q);
        gi[0].prog.access(1'b0, CFG_ADDR, 14'h0000, q);
        check("word", 14'h2aae, q);
        gi[0].prog.access(1'b0, 14'h2006, 14'h0000, q);
        check("other addr", 14'h3fff, q);
        gi[0].prog.set_mode(1'b0);
        gi[1].prog.set_mode(1'b1);
        gi[1].prog.access(1'b1, CFG_ADDR, 14'h15d1, q);
        gi[1].prog.access(1'b0, CFG_ADDR, 14'h0000, q);
        check("word b", 14'h15d1, q);
        gi[1].prog.set_mode(1'b0);
        #1 check("held", {4'h0, exp_dec(CFG_ERASED)}, {4'h0, dec(0)});
        // Crystal not yet stable keeps the core held
        @(posedge clk) osc_stable <= 1'b0;
        boot(14'h2a2e, 14'h15d1, 40, 40, 1'b0);
        @(posedge clk) osc_stable <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check("crystal ready", 14'h0, {12'h0, hold[0], hold[1]});
        burn(14'h2a0e);
        boot(14'h2a0e, 14'h15d1, 0, 8, 1'b1);
        burn(14'h0000);
        boot(14'h0000, 14'h15d1, PCNT, PCNT + 8, 1'b1);
        // Watchdog switched off by the word
        w0 = wdr_cnt;
        wdt_wait(2400);
        check("wdt off", 14'(w0), 14'(wdr_cnt));
        give_verdict();
    end
endmodule
